// ==== tcl_torque_limiter.sv ====
// torque command limiter: object store, enable sequence, slope
// limiter, speed limit and torque clamps in one module.
// assumes object requests and parameter inputs come from logic on
// ref_clk_i, and that the master keeps the 6,7,15 command order.
//
// Summary of operation
// - mode value 4 selects profile torque
// - setpoint signed 16-bit, -32767..32767, resets 0
// - slope limit, then speed, then clamps
// - ramp time is ms for rated step
// - ramp time 32-bit, default 500
// - clamp to forward and negated reverse limit
// - clamp symmetrically to maximum limit
// - clamps act in every control mode
// - limits load from default, peak-bounded
// - limits read-only signed 0.1 percent
`timescale 1ns/1ps
`default_nettype none
module tcl_torque_limiter
  import tcl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire tcl_obj_req_t obj_req_i,
  output tcl_obj_rsp_t obj_rsp_o,
  input wire logic [15:0] torque_limit_default_param_i,
  input wire logic [15:0] motor_peak_factor_param_i,
  input wire logic [15:0] motor_rated_factor_param_i,
  input wire logic [15:0] motor_scale_divisor_param_i,
  input wire logic signed [15:0] speed_limit_torque_i,
  input wire logic signed [15:0] ext_torque_i,
  output logic signed [15:0] torque_out_o,
  output logic torque_mode_o
);
  // ==========================================================
  // helpers
  function automatic logic signed [15:0] min_s(
    input logic signed [15:0] a,
    input logic signed [15:0] b);
    return (a < b) ? a : b;
  endfunction
  function automatic logic signed [15:0] max_s(
    input logic signed [15:0] a,
    input logic signed [15:0] b);
    return (a > b) ? a : b;
  endfunction
  // negation is safe because limits never hold -32768
  function automatic logic signed [15:0] neg_s(
    input logic signed [15:0] a);
    return -a;
  endfunction
  function automatic logic signed [15:0] clamp_s(
    input logic signed [15:0] x,
    input logic signed [15:0] hi,
    input logic signed [15:0] lo);
    return (x > hi) ? hi : ((x < lo) ? lo : x);
  endfunction

  // ==========================================================
  // object store and enable sequence
  logic [7:0] mode_r, mode_nxt; // operating_mode_selector
  logic [15:0] cmd_r, cmd_nxt; // drive_command_word
  logic signed [15:0] tset_r, tset_nxt; // torque_setpoint
  logic [31:0] ramp_r, ramp_nxt; // torque_ramp_time
  tcl_drv_st_t drv_r, drv_nxt; // enable state
  tcl_obj_rsp_t rsp_r, rsp_nxt; // registered answer
  logic signed [15:0] plim_r, nlim_r, peak_r; // torque limits
  logic [15:0] stat_w; // drive_status_word

  // status word follows the enable state
  always_comb begin
    case (drv_r)
      DRV_READY: stat_w = STAT_READY;
      DRV_SWON: stat_w = STAT_SWON;
      DRV_ENOP: stat_w = STAT_ENOP;
      default: stat_w = STAT_IDLE;
    endcase
  end

  // next values for the object store, one answer per request
  always_comb begin
    mode_nxt = mode_r;
    cmd_nxt = cmd_r;
    tset_nxt = tset_r;
    ramp_nxt = ramp_r;
    drv_nxt = drv_r;
    rsp_nxt = '0;
    if (obj_req_i.wr) begin
      rsp_nxt.ack = 1'b1;
      case (obj_req_i.idx)
        OBJ_CMD: begin
          cmd_nxt = obj_req_i.wdata[15:0];
          // steps 6, 7, 15 in order
          if (obj_req_i.wdata[15:0] == CMD_SHUTDOWN) begin
            drv_nxt = DRV_READY;
          end else if (obj_req_i.wdata[15:0] == CMD_SWITCH_ON && drv_r != DRV_IDLE) begin
            drv_nxt = DRV_SWON;
          end else if (obj_req_i.wdata[15:0] == CMD_ENABLE_OP && drv_r >= DRV_SWON) begin
            drv_nxt = DRV_ENOP;
          end else begin
            // anything out of order drops the drive
            drv_nxt = DRV_IDLE;
          end
        end
        OBJ_MODE: begin
          mode_nxt = obj_req_i.wdata[7:0];
        end
        OBJ_TSET: begin
          if ($signed(obj_req_i.wdata[15:0]) == TQ_ILLEGAL) begin
            rsp_nxt.err = 1'b1;
          end else begin
            tset_nxt = obj_req_i.wdata[15:0];
          end
        end
        OBJ_RAMP: begin
          ramp_nxt = obj_req_i.wdata;
        end
        default: rsp_nxt.err = 1'b1;
      endcase
    end else if (obj_req_i.rd) begin
      rsp_nxt.ack = 1'b1;
      // narrow objects sit in the low bits, upper bits zero
      case (obj_req_i.idx)
        OBJ_CMD: rsp_nxt.rdata = {16'h0000, cmd_r};
        // status is readable at any time
        OBJ_STAT: rsp_nxt.rdata = {16'h0000, stat_w};
        OBJ_MODE: rsp_nxt.rdata = {24'h000000, mode_r};
        OBJ_TSET: rsp_nxt.rdata = {16'h0000, tset_r};
        OBJ_RAMP: rsp_nxt.rdata = ramp_r;
        OBJ_PEAK: rsp_nxt.rdata = {16'h0000, peak_r};
        OBJ_PLIM: rsp_nxt.rdata = {16'h0000, plim_r};
        OBJ_NLIM: rsp_nxt.rdata = {16'h0000, nlim_r};
        default: rsp_nxt.err = 1'b1;
      endcase
    end
  end

  // register the object store
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_r <= RST_MODE;
      cmd_r <= RST_CMD;
      tset_r <= RST_TSET;
      ramp_r <= RST_RAMP;
      drv_r <= DRV_IDLE;
      rsp_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      cmd_r <= cmd_nxt;
      tset_r <= tset_nxt;
      ramp_r <= ramp_nxt;
      drv_r <= drv_nxt;
      rsp_r <= rsp_nxt;
    end
  end
  assign obj_rsp_o = rsp_r;

  // ==========================================================
  // power-on limit load
  tcl_init_st_t init_r, init_nxt; // load once after reset
  logic signed [15:0] plim_nxt, nlim_nxt, peak_nxt;
  logic [31:0] peak_prod; // peak factor times rated factor
  logic [31:0] peak_quot; // divided by the scale divisor
  logic signed [15:0] motor_peak; // saturated motor peak torque
  logic signed [15:0] dflt_lim; // default limit, range-bounded

  // motor peak torque; a zero divisor leaves it unbounded
  always_comb begin
    peak_prod = motor_peak_factor_param_i * motor_rated_factor_param_i;
    peak_quot = 32'h00000000;
    if (motor_scale_divisor_param_i != 16'h0000) begin
      peak_quot = peak_prod / {16'h0000, motor_scale_divisor_param_i};
    end
    if (motor_scale_divisor_param_i == 16'h0000 || peak_quot > 32'h00007FFF) begin
      motor_peak = TQ_MAX;
    end else begin
      motor_peak = peak_quot[15:0];
    end
    dflt_lim = max_s($signed(torque_limit_default_param_i), TQ_MIN);
  end

  // parameters are caught by a clocked load after release
  always_comb begin
    init_nxt = INIT_RUN;
    plim_nxt = plim_r;
    nlim_nxt = nlim_r;
    peak_nxt = peak_r;
    case (init_r)
      INIT_LOAD: begin
        // one default, bounded by motor peak
        plim_nxt = min_s(dflt_lim, motor_peak);
        nlim_nxt = min_s(dflt_lim, motor_peak);
        peak_nxt = min_s(dflt_lim, motor_peak);
      end
      default: init_nxt = INIT_RUN;
    endcase
  end

  // register the limits
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      init_r <= INIT_LOAD;
      plim_r <= RST_LIM;
      nlim_r <= RST_LIM;
      peak_r <= RST_LIM;
    end else begin
      init_r <= init_nxt;
      plim_r <= plim_nxt;
      nlim_r <= nlim_nxt;
      peak_r <= peak_nxt;
    end
  end

  // ==========================================================
  // slope limiter and output chain
  logic signed [15:0] ramp_out_r, ramp_out_nxt; // slope-limited setpoint
  logic [ACC_W-1:0] acc_r, acc_nxt; // cycles weighted by rated torque
  logic [ACC_W-1:0] acc_thr; // ramp time in cycles
  logic torque_act; // profile torque active
  logic signed [15:0] ramp_tgt; // slope limiter target
  logic signed [15:0] cmd_tq; // command before the clamps
  logic signed [15:0] clamp_hi, clamp_lo; // tightest bounds
  logic signed [15:0] out_nxt;
  logic signed [15:0] out_r;
  logic enop; // drive enabled

  // torque mode needs mode 4 and enable
  assign enop = (drv_r == DRV_ENOP);
  assign torque_act = enop && (mode_r == MODE_TORQUE);
  assign ramp_tgt = torque_act ? tset_r : RST_TSET;
  assign acc_thr = ACC_W'(ramp_r) * CYC_PER_MS;

  // one unit step each ramp_r*250 cycles gives rated torque in ramp_r ms
  always_comb begin
    acc_nxt = acc_r + RATED_TORQUE;
    ramp_out_nxt = ramp_out_r;
    if (!torque_act || ramp_r == 32'h00000000) begin
      // disabled drive or zero ramp: follow target at once
      acc_nxt = '0;
      ramp_out_nxt = ramp_tgt;
    end else if (ramp_out_r == ramp_tgt) begin
      acc_nxt = '0;
    end else if (acc_r + RATED_TORQUE >= acc_thr) begin
      acc_nxt = '0;
      if (ramp_out_r < ramp_tgt) begin
        ramp_out_nxt = ramp_out_r + 16'sh0001;
      end else begin
        ramp_out_nxt = ramp_out_r - 16'sh0001;
      end
    end
  end

  // output chain; the trade-off is one added cycle of latency
  always_comb begin
    // other modes feed the same clamps
    cmd_tq = ext_torque_i;
    if (torque_act) begin
      cmd_tq = clamp_s(ramp_out_r, speed_limit_torque_i, neg_s(speed_limit_torque_i));
    end
    // pick the tighter bound each side
    clamp_hi = min_s(plim_r, peak_r);
    clamp_lo = max_s(neg_s(nlim_r), neg_s(peak_r));
    out_nxt = enop ? clamp_s(cmd_tq, clamp_hi, clamp_lo) : RST_TSET;
  end

  // register the ramp and the output
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ramp_out_r <= RST_TSET;
      acc_r <= '0;
      out_r <= RST_TSET;
    end else begin
      ramp_out_r <= ramp_out_nxt;
      acc_r <= acc_nxt;
      out_r <= out_nxt;
    end
  end
  assign torque_out_o = out_r;
  assign torque_mode_o = torque_act;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  mode_entry_a: assert property (
    torque_mode_o |-> (mode_r == 8'h04 && drv_r == DRV_ENOP))
    else $error("torque mode without mode 4 and enable");
  setpoint_range_a: assert property (
    tset_r != 16'sh8000)
    else $error("setpoint holds -32768");
  ramp_step_a: assert property (
    (torque_act && $past(torque_act) && ramp_r != 0 && $stable(ramp_r))
    |-> (ramp_out_r - $past(ramp_out_r) <= 1 && $past(ramp_out_r) - ramp_out_r <= 1))
    else $error("ramp jumped more than one unit");
  ramp_reset_a: assert property (
    $rose(init_r == INIT_RUN) |-> (ramp_r == RST_RAMP))
    else $error("ramp time not 500 after reset");
  fwd_clamp_a: assert property (
    out_r <= plim_r || !$past(enop))
    else $error("output above forward limit");
  rev_clamp_a: assert property (
    out_r >= -nlim_r || !$past(enop))
    else $error("output below negated reverse limit");
  max_clamp_a: assert property (
    $past(enop) |-> (out_r <= peak_r && out_r >= -peak_r))
    else $error("output outside maximum limit");
  other_mode_a: assert property (
    (enop && !torque_act && ext_torque_i > plim_r && ext_torque_i > peak_r)
    |=> (out_r == min_s($past(plim_r), $past(peak_r))))
    else $error("other mode not clamped");
  limit_load_a: assert property (
    (init_r == INIT_LOAD) |=> (plim_r == nlim_r && nlim_r == peak_r && peak_r <= $past(motor_peak)))
    else $error("limits not loaded from default");
  limit_ro_a: assert property (
    (obj_req_i.wr && obj_req_i.idx == 16'h60E0 && init_r == INIT_RUN) |=> (obj_rsp_o.err && $stable(plim_r)))
    else $error("limit object accepted a write");
  off_zero_a: assert property (
    !enop |=> (torque_out_o == 0))
    else $error("torque output while disabled");

  enable_seq_c: cover property (drv_r == DRV_SWON ##[1:50] drv_r == DRV_ENOP);
  ramp_done_c: cover property (torque_act && tset_r != 0 && ramp_out_r == tset_r);
  clamp_hit_c: cover property (enop && cmd_tq > clamp_hi);
endmodule
`default_nettype wire

// ==== tcl_pkg.sv ====
// torque command limiter package: object indices, reset values,
// timing constants, bus carrier structs and state encodings.
// assumes a single 250 MHz drive control clock.
package tcl_pkg;
  // ==========================================================
  // object indices on the object access port
  localparam logic [15:0] OBJ_CMD = 16'h6040; // drive_command_word
  localparam logic [15:0] OBJ_STAT = 16'h6041; // drive_status_word
  localparam logic [15:0] OBJ_MODE = 16'h6060; // operating_mode_selector
  localparam logic [15:0] OBJ_TSET = 16'h6071; // torque_setpoint
  localparam logic [15:0] OBJ_PEAK = 16'h6072; // peak_torque_limit
  localparam logic [15:0] OBJ_RAMP = 16'h6087; // torque_ramp_time
  localparam logic [15:0] OBJ_PLIM = 16'h60E0; // positive_torque_limit
  localparam logic [15:0] OBJ_NLIM = 16'h60E1; // negative_torque_limit
  // ==========================================================
  // mode, command and status encodings
  localparam logic [7:0] MODE_TORQUE = 8'h04;
  localparam logic [15:0] CMD_SHUTDOWN = 16'h0006;
  localparam logic [15:0] CMD_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CMD_ENABLE_OP = 16'h000F;
  localparam logic [15:0] STAT_IDLE = 16'h0040;
  localparam logic [15:0] STAT_READY = 16'h0021;
  localparam logic [15:0] STAT_SWON = 16'h0023;
  localparam logic [15:0] STAT_ENOP = 16'h0027;
  // ==========================================================
  // reset values and ranges
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_CMD = 16'h0000;
  localparam logic signed [15:0] RST_TSET = 16'sh0000;
  localparam logic [31:0] RST_RAMP = 32'h000001F4;
  localparam logic signed [15:0] RST_LIM = 16'sh0000;
  localparam logic signed [15:0] TQ_MAX = 16'sh7FFF;
  localparam logic signed [15:0] TQ_MIN = -16'sh7FFF;
  localparam logic signed [15:0] TQ_ILLEGAL = 16'sh8000;
  // ==========================================================
  // timing: rated torque is 1000 units of 0.1 percent
  localparam longint CLK_FREQ_HZ = 250000000;
  localparam longint MS_PER_S = 1000;
  localparam int ACC_W = 52;
  localparam logic [ACC_W-1:0] CYC_PER_MS = ACC_W'(CLK_FREQ_HZ / MS_PER_S);
  localparam logic [ACC_W-1:0] RATED_TORQUE = 52'h00000000003E8;
  // ==========================================================
  // carriers and states
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] idx;
    logic [31:0] wdata;
  } tcl_obj_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } tcl_obj_rsp_t;
  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_READY = 2'b01,
    DRV_SWON = 2'b10,
    DRV_ENOP = 2'b11
  } tcl_drv_st_t;
  typedef enum logic [0:0] {
    INIT_LOAD = 1'b0,
    INIT_RUN = 1'b1
  } tcl_init_st_t;
endpackage

// ==== tcl_fieldbus_master.sv ====
// fieldbus master model: issues one-cycle object requests to the limiter.
// assumes the limiter registers its ack on the same edge that takes the request.
`timescale 1ns/1ps
`default_nettype none
module tcl_fieldbus_master
  import tcl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire tcl_obj_rsp_t obj_rsp_i,
  output var tcl_obj_req_t obj_req_o
);
  // ==========================================================
  // request driver
  // quiet at time zero so no request precedes reset release
  initial begin
    obj_req_o = '0;
  end

  // one transfer; the answer is sampled once settled after the taking edge
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic ok);
    @(posedge ref_clk_i);
    obj_req_o <= '{wr: w, rd: !w, idx: idx, wdata: wd};
    @(posedge ref_clk_i);
    // released fields show inverted values, so stale data never looks valid
    obj_req_o <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~wd};
    #1;
    ok = (obj_rsp_i.ack === 1'b1);
    err = obj_rsp_i.err;
    rd = obj_rsp_i.rdata;
  endtask

  task automatic enable_seq(output logic [31:0] st);
    logic [31:0] r;
    logic e;
    logic ok;
    xfer(1'b1, OBJ_CMD, 32'h6, r, e, ok);
    xfer(1'b1, OBJ_CMD, 32'h7, r, e, ok);
    xfer(1'b1, OBJ_CMD, 32'hF, r, e, ok);
    xfer(1'b0, OBJ_STAT, 32'h0, st, e, ok);
  endtask
endmodule
`default_nettype wire

// ==== torque_command_limiter_tb.sv ====
// testbench for the torque command limiter: register access, enable order,
// clamps in both modes and the slope limiter. assumes a 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module torque_command_limiter_tb
  import tcl_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  tcl_obj_req_t obj_req;
  tcl_obj_rsp_t obj_rsp;
  logic signed [15:0] speed_lim = 16'sh7FFF;
  logic signed [15:0] ext_tq = 16'sh0000;
  logic [15:0] dflt_par = 16'h0320; // stored default limit, lowered on the edge that asserts the second reset
  logic signed [15:0] torque_out;
  logic torque_mode;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;

  // ==========================================================
  // clock, design and master
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // default 800 is bounded by motor peak 3*100/1 = 300; the later 200 is not
  tcl_torque_limiter dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .obj_req_i(obj_req),
    .obj_rsp_o(obj_rsp), .torque_limit_default_param_i(dflt_par),
    .motor_peak_factor_param_i(16'h0003), .motor_rated_factor_param_i(16'h0064),
    .motor_scale_divisor_param_i(16'h0001), .speed_limit_torque_i(speed_lim),
    .ext_torque_i(ext_tq), .torque_out_o(torque_out), .torque_mode_o(torque_mode));
  tcl_fieldbus_master m_u (.ref_clk_i(ref_clk_i), .obj_rsp_i(obj_rsp), .obj_req_o(obj_req));

  // ==========================================================
  // shared checks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access with its ack, err flag and read data judged
  task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic e;
    logic ok;
    m_u.xfer(w, idx, d, r, e, ok);
    chk({31'h0, ok}, 32'h1);
    chk({31'h0, e}, {31'h0, xe});
    if (!w) begin
      chk(r, xe ? 32'h0 : d);
    end
  endtask
  // output torque after a few cycles, so the one-cycle latency has passed
  task automatic tq(input logic signed [15:0] exp, input logic md);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk({16'h0, torque_out}, {16'h0, exp});
    chk({31'h0, torque_mode}, {31'h0, md});
  endtask
  task automatic drive(input logic signed [15:0] e, input logic signed [15:0] s);
    @(posedge ref_clk_i);
    ext_tq <= e;
    speed_lim <= s;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    acc(1'b0, OBJ_TSET, 32'h0, 1'b0);
    acc(1'b0, OBJ_RAMP, 32'h1F4, 1'b0);
    acc(1'b0, OBJ_STAT, {16'h0, STAT_IDLE}, 1'b0);
    acc(1'b0, OBJ_PLIM, 32'h12C, 1'b0);
    acc(1'b0, OBJ_NLIM, 32'h12C, 1'b0);
    acc(1'b0, OBJ_PEAK, 32'h12C, 1'b0);
    tq(16'sh0000, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_access();
    logic [15:0] ro [5];
    ro = '{OBJ_STAT, OBJ_PEAK, OBJ_PLIM, OBJ_NLIM, 16'h1234};
    // status, read-only limits and an unmapped index refuse writes
    foreach (ro[i]) begin
      acc(1'b1, ro[i], 32'h64, 1'b1);
    end
    acc(1'b0, OBJ_PLIM, 32'h12C, 1'b0);
    acc(1'b0, 16'h1234, 32'h0, 1'b1);
    acc(1'b1, OBJ_TSET, 32'h8000, 1'b1);
    acc(1'b0, OBJ_TSET, 32'h0, 1'b0);
    acc(1'b1, OBJ_TSET, 32'h7FFF, 1'b0);
    acc(1'b0, OBJ_TSET, 32'h7FFF, 1'b0);
    acc(1'b1, OBJ_TSET, 32'h0, 1'b0);
    $display("test access done");
  endtask

  task automatic t_other_mode();
    logic [31:0] st;
    m_u.enable_seq(st);
    chk(st, {16'h0, STAT_ENOP});
    drive(16'sd1000, 16'sh7FFF);
    tq(16'sd300, 1'b0);
    drive(-16'sd1000, 16'sh7FFF);
    tq(-16'sd300, 1'b0);
    drive(16'sd100, 16'sh7FFF);
    tq(16'sd100, 1'b0);
    $display("test other mode done");
  endtask

  task automatic t_torque_mode();
    acc(1'b1, OBJ_MODE, 32'h4, 1'b0);
    acc(1'b1, OBJ_RAMP, 32'h0, 1'b0);
    // the external command must be ignored in torque mode
    drive(16'sd5, 16'sd150);
    acc(1'b1, OBJ_TSET, 32'hC8, 1'b0);
    tq(16'sd150, 1'b1);
    drive(16'sd5, 16'sd1000);
    tq(16'sd200, 1'b1);
    acc(1'b1, OBJ_TSET, 32'h3E8, 1'b0);
    tq(16'sd300, 1'b1);
    acc(1'b1, OBJ_TSET, 32'hFC18, 1'b0);
    tq(-16'sd300, 1'b1);
    acc(1'b1, OBJ_TSET, 32'h0, 1'b0);
    tq(16'sd0, 1'b1);
    // ramp 1 ms: one unit every 250 cycles, so 4 units take 1000 cycles
    acc(1'b1, OBJ_RAMP, 32'h1, 1'b0);
    acc(1'b1, OBJ_TSET, 32'h4, 1'b0);
    repeat (600) @(posedge ref_clk_i);
    tq(16'sd2, 1'b1);
    repeat (500) @(posedge ref_clk_i);
    tq(16'sd4, 1'b1);
    $display("test torque mode done");
  endtask

  task automatic t_out_of_order();
    acc(1'b0, OBJ_MODE, 32'h4, 1'b0);
    // 7 while enabled steps back to switched on and removes torque
    acc(1'b1, OBJ_CMD, 32'h7, 1'b0);
    acc(1'b0, OBJ_STAT, {16'h0, STAT_SWON}, 1'b0);
    tq(16'sd0, 1'b0);
    acc(1'b1, OBJ_CMD, 32'h6, 1'b0);
    acc(1'b0, OBJ_STAT, {16'h0, STAT_READY}, 1'b0);
    // 15 straight from ready skips a step and drops the drive
    acc(1'b1, OBJ_CMD, 32'hF, 1'b0);
    acc(1'b0, OBJ_STAT, {16'h0, STAT_IDLE}, 1'b0);
    acc(1'b0, OBJ_CMD, 32'hF, 1'b0);
    acc(1'b1, OBJ_CMD, 32'h7, 1'b0);
    acc(1'b0, OBJ_STAT, {16'h0, STAT_IDLE}, 1'b0);
    tq(16'sd0, 1'b0);
    $display("test out of order done");
  endtask

  // second reset with a lower default: objects return to reset values
  task automatic t_reinit();
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    dflt_par <= 16'h00C8;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // one edge for the limit load cycle after release
    repeat (2) @(posedge ref_clk_i);
    acc(1'b0, OBJ_MODE, 32'h0, 1'b0);
    acc(1'b0, OBJ_RAMP, 32'h1F4, 1'b0);
    acc(1'b0, OBJ_STAT, {16'h0, STAT_IDLE}, 1'b0);
    acc(1'b0, OBJ_PLIM, 32'hC8, 1'b0);
    acc(1'b0, OBJ_NLIM, 32'hC8, 1'b0);
    acc(1'b0, OBJ_PEAK, 32'hC8, 1'b0);
    tq(16'sd0, 1'b0);
    $display("test reinit done");
  endtask

  // ==========================================================
  // closing report and hang guard
  task automatic end_sim();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // the tests need about 1300 cycles; 20000 means a hang
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // one edge for the limit load cycle after release
    repeat (2) @(posedge ref_clk_i);
    t_reset();
    t_access();
    t_other_mode();
    t_torque_mode();
    t_out_of_order();
    t_reinit();
    end_sim();
  end
endmodule
`default_nettype wire
